/* File: vpfr_top.sv */
// Output-voltage protection registers and fault response for two channels.
// Assumes a command engine on SYS_CLK presents decoded transactions.
// Behaviour
// - Overvoltage latches off and sets three status bits
// - Overvoltage action is read-only, Read Byte only
// - Both fault actions shared, page ignored
// - Page 00h A, 01h B, FFh both
// - Exceeding maximum limit is a warning only
// - Commanded output clamped to maximum limit
// - Limit violation sets OTHER, Limit_violation_warning_bit bits
// - Unmasked events drive the host alert
// - Maximum limit word, upper byte zero, NVM
// - Undervoltage threshold from command, shift, offset
// - Undervoltage limit paged read-only word
// - Undervoltage sets OTHER, VOUT, UV fault bits
// - Undervoltage action byte, read/write, NVM reset
// - Action 00h reports but keeps converting
// - Action BAh stops channel, retries after 20ms
// - Latched channel clears only by disable
// - Overvoltage limit FFh or maximum plus offset
`timescale 1ns/1ps
`default_nettype none
module vpfr_top #(parameter int RETRY_CYCLES = vpfr_pkg::RETRY_CYCLES_DFLT) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Command transactions
   input wire logic CMD_VALID,
   input wire logic CMD_WRITE,
   input wire logic CMD_WORD,
   input wire logic [7:0] CMD_CODE,
   input wire logic [15:0] CMD_WDATA,
   input wire logic [7:0] PAGE_SEL,
   input wire logic STATUS_CLEAR,
   // Answers
   output logic RD_VALID,
   output logic [15:0] RD_DATA,
   output logic CMD_ERROR,
   // Nonvolatile defaults
   input wire logic [7:0] NVM_VMAX_A,
   input wire logic [7:0] NVM_VMAX_B,
   input wire logic [7:0] NVM_UV_ACTION,
   // Configuration from neighbouring logic
   input wire logic [1:0] OPER_ON,
   input wire logic [1:0] MARGIN_HIGH_ON,
   input wire logic [1:0] MARGIN_LOW_ON,
   input wire logic DAC_5MV_SEL,
   input wire logic [7:0] LOADLINE_SHIFT_A,
   input wire logic [7:0] LOADLINE_SHIFT_B,
   input wire logic [7:0] ALERT_MASK_VOUT,
   // Pins
   input wire logic [1:0] CHANNEL_ENABLE_PINS,
   input wire logic [1:0] OV_COMP_PINS,
   input wire logic [1:0] UV_COMP_PINS,
   // Channel outputs and status
   output logic [1:0] CHANNEL_RUN,
   output logic [7:0] VOUT_TARGET_A,
   output logic [7:0] VOUT_TARGET_B,
   output logic [7:0] STATUS_VOUT_A,
   output logic [7:0] STATUS_VOUT_B,
   output logic [7:0] STATUS_BYTE_A,
   output logic [7:0] STATUS_BYTE_B,
   output logic [1:0] STATUS_WORD_VOUT,
   output logic HOST_ALERT_PIN_O,
   output logic HOST_ALERT_PIN_OE
);
   import vpfr_pkg::*;

   // ************************************************
   // Pin synchronisation and channel sequencers
   // ************************************************
   logic [1:0] en_sync, ov_sync, uv_sync;
   logic [1:0] ov_evt, uv_evt;
   logic [7:0] uv_act_ff, nxt_uv_act;
   vpfr_chan_if chan_bus[2] ();

   vpfr_sync #(.W(6)) u_sync (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .d({CHANNEL_ENABLE_PINS, OV_COMP_PINS, UV_COMP_PINS}),
      .q({en_sync, ov_sync, uv_sync})
   );

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign chan_bus[g].ov_fault = ov_sync[g];
      assign chan_bus[g].uv_fault = uv_sync[g];
      // Dropping either enable clears a latched channel
      assign chan_bus[g].enable = en_sync[g] & OPER_ON[g];
      assign chan_bus[g].uv_action = uv_act_ff;
      assign CHANNEL_RUN[g] = chan_bus[g].run;
      assign ov_evt[g] = chan_bus[g].ov_evt;
      assign uv_evt[g] = chan_bus[g].uv_evt;
      vpfr_chan #(.RETRY_CYCLES(RETRY_CYCLES)) u_chan (
         .clk(SYS_CLK),
         .rst(SYS_RST),
         .bus(chan_bus[g])
      );
   end

   // ************************************************
   // Command decode and stored settings
   // ************************************************
   logic load_ff;
   logic [7:0] vmax_ff [2];
   logic [7:0] nxt_vmax [2];
   logic [7:0] vset_ff [2][3];
   logic [7:0] nxt_vset [2][3];
   logic [1:0] eval_ff, nxt_eval;
   logic rd_valid_ff, nxt_rd_valid, err_ff, nxt_err;
   logic [15:0] rd_data_ff, nxt_rd_data;
   logic [7:0] tgt_ff [2];
   logic [7:0] uvt_ff [2];
   logic [7:0] ovl_ff [2];
   logic [7:0] nvm_vmax [2];
   logic [1:0] sel;
   logic page_ok, rch, wr;
   logic [1:0] k;

   assign nvm_vmax[0] = NVM_VMAX_A;
   assign nvm_vmax[1] = NVM_VMAX_B;
   assign sel[0] = (PAGE_SEL == PAGE_A) || (PAGE_SEL == PAGE_ALL);
   assign sel[1] = (PAGE_SEL == PAGE_B) || (PAGE_SEL == PAGE_ALL);
   assign page_ok = |sel;
   // A read with both pages selected answers from channel A
   assign rch = (PAGE_SEL == PAGE_B);
   assign wr = CMD_VALID && CMD_WRITE;

   always_comb begin
      k = 2'd0;
      nxt_vmax = vmax_ff;
      nxt_vset = vset_ff;
      nxt_uv_act = uv_act_ff;
      nxt_eval = '0;
      nxt_err = 1'b0;
      nxt_rd_valid = 1'b0;
      nxt_rd_data = '0;
      if (!load_ff) begin
         nxt_vmax = nvm_vmax;
         nxt_uv_act = NVM_UV_ACTION;
      end else if (CMD_VALID) begin
         case (CMD_CODE)
            CMD_VMAX: begin
               if (!CMD_WORD || !page_ok) begin
                  nxt_err = 1'b1;
               end else if (CMD_WRITE) begin
                  for (int c = 0; c < 2; c++) begin
                     if (sel[c]) begin
                        // Upper byte of the write is dropped
                        nxt_vmax[c] = CMD_WDATA[7:0];
                        nxt_eval[c] = 1'b1;
                     end
                  end
               end else begin
                  nxt_rd_valid = 1'b1;
                  nxt_rd_data = {BYTE_ZERO, vmax_ff[rch]};
               end
            end
            CMD_VOUT, CMD_MHI, CMD_MLO: begin
               k = (CMD_CODE == CMD_MHI) ? 2'd1 : ((CMD_CODE == CMD_MLO) ? 2'd2 : 2'd0);
               if (wr && CMD_WORD && page_ok) begin
                  for (int c = 0; c < 2; c++) begin
                     if (sel[c]) begin
                        nxt_vset[c][k] = CMD_WDATA[7:0];
                        nxt_eval[c] = 1'b1;
                     end
                  end
               end
            end
            CMD_OVLIM, CMD_UVLIM: begin
               if (CMD_WRITE || !CMD_WORD || !page_ok) begin
                  nxt_err = 1'b1;
               end else begin
                  nxt_rd_valid = 1'b1;
                  nxt_rd_data = (CMD_CODE == CMD_OVLIM) ? {BYTE_ZERO, ovl_ff[rch]}
                                                        : {BYTE_ZERO, uvt_ff[rch]};
               end
            end
            CMD_OVRESP: begin
               if (CMD_WRITE || CMD_WORD) begin
                  nxt_err = 1'b1;
               end else begin
                  nxt_rd_valid = 1'b1;
                  nxt_rd_data = {BYTE_ZERO, OV_ACTION};
               end
            end
            CMD_UVRESP: begin
               if (CMD_WORD) begin
                  nxt_err = 1'b1;
               end else if (CMD_WRITE) begin
                  if (CMD_WDATA[7:0] == ACT_IGNORE || CMD_WDATA[7:0] == ACT_LATCH
                      || CMD_WDATA[7:0] == ACT_RETRY) begin
                     nxt_uv_act = CMD_WDATA[7:0];
                  end else begin
                     nxt_err = 1'b1;
                  end
               end else begin
                  nxt_rd_valid = 1'b1;
                  nxt_rd_data = {BYTE_ZERO, uv_act_ff};
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         load_ff <= 1'b0;
         vmax_ff <= '{default: '0};
         vset_ff <= '{default: '{default: '0}};
         uv_act_ff <= ACT_IGNORE;
         eval_ff <= '0;
         err_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
      end else begin
         load_ff <= 1'b1;
         vmax_ff <= nxt_vmax;
         vset_ff <= nxt_vset;
         uv_act_ff <= nxt_uv_act;
         eval_ff <= nxt_eval;
         err_ff <= nxt_err;
         rd_valid_ff <= nxt_rd_valid;
         rd_data_ff <= nxt_rd_data;
      end
   end

   // ************************************************
   // Clamp, thresholds and limit warning
   // ************************************************
   logic [7:0] nxt_tgt [2];
   logic [7:0] nxt_uvt [2];
   logic [7:0] nxt_ovl [2];
   logic [7:0] shift [2];
   logic [7:0] req [2];
   logic [1:0] warn_ff, nxt_warn;
   logic [8:0] uv_sub [2];
   logic [8:0] ov_sum [2];

   assign shift[0] = LOADLINE_SHIFT_A;
   assign shift[1] = LOADLINE_SHIFT_B;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         req[c] = MARGIN_HIGH_ON[c] ? vset_ff[c][1]
                  : (MARGIN_LOW_ON[c] ? vset_ff[c][2] : vset_ff[c][0]);
         nxt_tgt[c] = (req[c] > vmax_ff[c]) ? vmax_ff[c] : req[c];
         // Threshold floors at code zero rather than wrapping
         uv_sub[c] = {1'b0, shift[c]} + {1'b0, UV_OFFSET};
         nxt_uvt[c] = ({1'b0, tgt_ff[c]} > uv_sub[c])
                      ? 8'(({1'b0, tgt_ff[c]} - uv_sub[c])) : BYTE_ZERO;
         ov_sum[c] = {1'b0, vmax_ff[c]} + {1'b0, OV_OFFSET};
         nxt_ovl[c] = (DAC_5MV_SEL || ov_sum[c][8]) ? VID_FULL : ov_sum[c][7:0];
         // Any stored setting above the limit is flagged, never faulted
         nxt_warn[c] = eval_ff[c] && ((vset_ff[c][0] > vmax_ff[c])
                       || (vset_ff[c][1] > vmax_ff[c]) || (vset_ff[c][2] > vmax_ff[c]));
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tgt_ff <= '{default: '0};
         uvt_ff <= '{default: '0};
         ovl_ff <= '{default: '0};
         warn_ff <= '0;
      end else begin
         tgt_ff <= nxt_tgt;
         uvt_ff <= nxt_uvt;
         ovl_ff <= nxt_ovl;
         warn_ff <= nxt_warn;
      end
   end

   // ************************************************
   // Sticky status and host alert
   // ************************************************
   logic [7:0] svo_ff [2];
   logic [7:0] nxt_svo [2];
   logic [7:0] sbyte_ff [2];
   logic [7:0] nxt_sbyte [2];
   logic [1:0] sword_ff, nxt_sword;
   logic alert_ff, nxt_alert;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // Clear applies first so a same-cycle event survives it
         nxt_svo[c] = STATUS_CLEAR ? BYTE_ZERO : svo_ff[c];
         nxt_sbyte[c] = STATUS_CLEAR ? BYTE_ZERO : sbyte_ff[c];
         nxt_sword[c] = STATUS_CLEAR ? 1'b0 : sword_ff[c];
         if (ov_evt[c]) begin
            nxt_svo[c][SVO_OV] = 1'b1;
            nxt_sbyte[c][STB_OV] = 1'b1;
         end
         if (uv_evt[c]) begin
            nxt_svo[c][SVO_UV] = 1'b1;
            nxt_sbyte[c][STB_OTHER] = 1'b1;
         end
         if (warn_ff[c]) begin
            nxt_svo[c][SVO_MINMAX] = 1'b1;
            nxt_sbyte[c][STB_OTHER] = 1'b1;
         end
         if (ov_evt[c] || uv_evt[c] || warn_ff[c]) nxt_sword[c] = 1'b1;
      end
      nxt_alert = |((svo_ff[0] | svo_ff[1]) & ~ALERT_MASK_VOUT);
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         svo_ff <= '{default: '0};
         sbyte_ff <= '{default: '0};
         sword_ff <= '0;
         alert_ff <= 1'b0;
      end else begin
         svo_ff <= nxt_svo;
         sbyte_ff <= nxt_sbyte;
         sword_ff <= nxt_sword;
         alert_ff <= nxt_alert;
      end
   end

   assign RD_VALID = rd_valid_ff;
   assign RD_DATA = rd_data_ff;
   assign CMD_ERROR = err_ff;
   assign VOUT_TARGET_A = tgt_ff[0];
   assign VOUT_TARGET_B = tgt_ff[1];
   assign STATUS_VOUT_A = svo_ff[0];
   assign STATUS_VOUT_B = svo_ff[1];
   assign STATUS_BYTE_A = sbyte_ff[0];
   assign STATUS_BYTE_B = sbyte_ff[1];
   assign STATUS_WORD_VOUT = sword_ff;
   // Open-drain alert: the pad only ever pulls low
   assign HOST_ALERT_PIN_O = 1'b0;
   assign HOST_ALERT_PIN_OE = alert_ff;

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   chk_ov_status_set: assert property (ov_evt[0] |=>
      svo_ff[0][SVO_OV] && sbyte_ff[0][STB_OV] && sword_ff[0]) else $error("ov status missing");
   chk_ov_resp_ro: assert property ((load_ff && wr && CMD_CODE == CMD_OVRESP) |=>
      CMD_ERROR && !RD_VALID) else $error("ov action write accepted");
   chk_uv_act_shared: assert property ((load_ff && wr && !CMD_WORD && CMD_CODE == CMD_UVRESP
      && CMD_WDATA[7:0] == ACT_RETRY) |=> uv_act_ff == ACT_RETRY) else $error("uv action lost");
   chk_page_both: assert property ((load_ff && wr && CMD_WORD && CMD_CODE == CMD_VMAX
      && PAGE_SEL == PAGE_ALL) |=> vmax_ff[0] == vmax_ff[1]) else $error("page all missed one");
   chk_clamp_tgt: assert property (load_ff |=> tgt_ff[1] <= $past(vmax_ff[1]))
      else $error("target above limit");
   chk_warn_status: assert property (warn_ff[1] |=>
      svo_ff[1][SVO_MINMAX] && sbyte_ff[1][STB_OTHER] && !svo_ff[1][SVO_OV])
      else $error("warning status missing");
   chk_alert_mask: assert property ((|((svo_ff[0] | svo_ff[1]) & ~ALERT_MASK_VOUT))
      |=> HOST_ALERT_PIN_OE) else $error("alert not raised");
   chk_vmax_upper: assert property ((load_ff && CMD_VALID && !CMD_WRITE && CMD_WORD
      && CMD_CODE == CMD_VMAX && page_ok) |=> RD_VALID && RD_DATA[15:8] == BYTE_ZERO)
      else $error("maximum limit read bad");
   chk_uv_status: assert property (uv_evt[1] |=>
      svo_ff[1][SVO_UV] && sbyte_ff[1][STB_OTHER] && sword_ff[1]) else $error("uv status missing");
   chk_bad_uv_code: assert property ((load_ff && wr && !CMD_WORD && CMD_CODE == CMD_UVRESP
      && CMD_WDATA[7:0] == VID_FULL) |=> CMD_ERROR && uv_act_ff == $past(uv_act_ff))
      else $error("bad uv code accepted");
   chk_ov_dac5: assert property (DAC_5MV_SEL |=> ovl_ff[0] == VID_FULL)
      else $error("ov limit not full scale");

   cov_ov_event: cover property (ov_evt[0] ##1 HOST_ALERT_PIN_OE ##1 HOST_ALERT_PIN_OE);
   cov_warn: cover property (warn_ff[0]);
   cov_uv_event: cover property (uv_evt[1]);
endmodule : vpfr_top
`default_nettype wire

/* File: vpfr_pkg.sv */
// Constants, command codes and types for the output-voltage protection block.
// Assumes a 20 MHz system clock; shared by vpfr_top, vpfr_chan and the bench.
package vpfr_pkg;
   // ************************************************
   // Command codes
   // ************************************************
   localparam logic [7:0] CMD_VOUT = 8'h21;
   localparam logic [7:0] CMD_VMAX = 8'h24;
   localparam logic [7:0] CMD_MHI = 8'h25;
   localparam logic [7:0] CMD_MLO = 8'h26;
   localparam logic [7:0] CMD_OVLIM = 8'h40;
   localparam logic [7:0] CMD_OVRESP = 8'h41;
   localparam logic [7:0] CMD_UVLIM = 8'h44;
   localparam logic [7:0] CMD_UVRESP = 8'h45;
   // ************************************************
   // Page values and action codes
   // ************************************************
   localparam logic [7:0] PAGE_A = 8'h00;
   localparam logic [7:0] PAGE_B = 8'h01;
   localparam logic [7:0] PAGE_ALL = 8'hFF;
   localparam logic [7:0] ACT_IGNORE = 8'h00;
   localparam logic [7:0] ACT_LATCH = 8'h80;
   localparam logic [7:0] ACT_RETRY = 8'hBA;
   localparam logic [7:0] OV_ACTION = ACT_LATCH;
   // ************************************************
   // Status bit positions and limits
   // ************************************************
   localparam int STB_OTHER = 0;
   localparam int STB_OV = 5;
   localparam int SVO_MINMAX = 3;
   localparam int SVO_UV = 4;
   localparam int SVO_OV = 7;
   localparam logic [7:0] VID_FULL = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Fixed offsets in VID steps; value is a plain default
   localparam logic [7:0] UV_OFFSET = 8'h0A;
   localparam logic [7:0] OV_OFFSET = 8'h0A;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_KHZ = 20000;
   localparam int RETRY_MS = 20;
   localparam int RETRY_CYCLES_DFLT = RETRY_MS * CLK_KHZ;
   localparam int CNT_W = 20;
   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_LATCH, ST_WAIT} vpfr_state_type;
endpackage : vpfr_pkg

/* File: vpfr_chan_if.sv */
// Carrier between the register logic and one channel's fault sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface vpfr_chan_if;
   logic ov_fault;
   logic uv_fault;
   logic enable;
   logic [7:0] uv_action;
   logic run;
   logic ov_evt;
   logic uv_evt;
   modport ctl (output ov_fault, uv_fault, enable, uv_action, input run, ov_evt, uv_evt);
   modport chan (input ov_fault, uv_fault, enable, uv_action, output run, ov_evt, uv_evt);
endinterface : vpfr_chan_if
`default_nettype wire

/* File: vpfr_sync.sv */
// Two-flop synchroniser for pin levels.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module vpfr_sync #(parameter int W = 1) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end
   assign q = q_ff;
endmodule : vpfr_sync
`default_nettype wire

/* File: vpfr_chan.sv */
// Fault sequencer of one output channel: latch-off, ignore, retry.
// Assumes fault and enable inputs are already synchronised.
`timescale 1ns/1ps
`default_nettype none
module vpfr_chan #(parameter int RETRY_CYCLES = vpfr_pkg::RETRY_CYCLES_DFLT) (
   input wire logic clk,
   input wire logic rst,
   vpfr_chan_if.chan bus
);
   import vpfr_pkg::*;
   vpfr_state_type state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic run_ff, ov_evt_ff, uv_evt_ff, uv_prev_ff;
   logic nxt_ov_evt, nxt_uv_evt;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ov_evt = 1'b0;
      nxt_uv_evt = 1'b0;
      unique case (state_ff)
         ST_OFF: begin
            if (bus.enable) nxt_state = ST_RUN;
         end
         ST_RUN: begin
            if (!bus.enable) begin
               nxt_state = ST_OFF;
            end else if (bus.ov_fault) begin
               nxt_ov_evt = 1'b1;
               nxt_state = ST_LATCH;
            end else if (bus.uv_fault) begin
               // Ignore mode reports only the onset, not every cycle
               nxt_uv_evt = (bus.uv_action != ACT_IGNORE) || !uv_prev_ff;
               if (bus.uv_action == ACT_RETRY) begin
                  nxt_state = ST_WAIT;
                  nxt_cnt = CNT_W'(RETRY_CYCLES - 1);
               end else if (bus.uv_action != ACT_IGNORE) begin
                  // Unknown stored codes fall back to latch-off, the safe choice
                  nxt_state = ST_LATCH;
               end
            end
         end
         ST_LATCH: begin
            if (!bus.enable) nxt_state = ST_OFF;
         end
         ST_WAIT: begin
            if (!bus.enable) begin
               nxt_state = ST_OFF;
            end else if (cnt_ff == '0) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_OFF;
         cnt_ff <= '0;
         run_ff <= 1'b0;
         ov_evt_ff <= 1'b0;
         uv_evt_ff <= 1'b0;
         uv_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         run_ff <= (nxt_state == ST_RUN);
         ov_evt_ff <= nxt_ov_evt;
         uv_evt_ff <= nxt_uv_evt;
         uv_prev_ff <= bus.uv_fault;
      end
   end

   assign bus.run = run_ff;
   assign bus.ov_evt = ov_evt_ff;
   assign bus.uv_evt = uv_evt_ff;

   // ************************************************
   // Checks
   // ************************************************
   chk_ov_latch_off: assert property (@(posedge clk) disable iff (rst)
      bus.ov_evt |-> !bus.run ##1 !bus.run) else $error("run after overvoltage");
   chk_ignore_runs: assert property (@(posedge clk) disable iff (rst)
      (state_ff == ST_RUN && bus.enable && !bus.ov_fault && bus.uv_fault
       && bus.uv_action == ACT_IGNORE) |=> run_ff) else $error("ignore mode stopped");
   chk_retry_hold: assert property (@(posedge clk) disable iff (rst)
      (state_ff == ST_RUN && nxt_state == ST_WAIT) |=> !run_ff [*8])
      else $error("retry restarted early");
   chk_latch_hold: assert property (@(posedge clk) disable iff (rst)
      (state_ff == ST_LATCH && bus.enable) |=> state_ff == ST_LATCH)
      else $error("latch released while enabled");
   cov_retry: cover property (@(posedge clk) disable iff (rst)
      state_ff == ST_WAIT ##1 state_ff == ST_RUN);
endmodule : vpfr_chan
`default_nettype wire

/* File: vpfr_host.sv */
// Host model: presents one decoded command per call on the command port.
// Assumes the bench calls send from one process only.
`timescale 1ns/1ps
`default_nettype none
module vpfr_host (
   // Command port
   input wire logic clk,
   output logic valid,
   output logic write,
   output logic word,
   output logic [7:0] code,
   output logic [15:0] wdata,
   output logic [7:0] page
);
   initial {valid, write, word, code, wdata, page} = '0;
   // Width and target chosen by caller
   task automatic send(input logic w, wd, input logic [7:0] c, input logic [15:0] d,
      input logic [7:0] p);
      @(posedge clk);
      #2 {valid, write, word, code, wdata, page} = {1'b1, w, wd, c, d, p};
      @(posedge clk);
      #2 valid = 1'b0;
   endtask : send
endmodule : vpfr_host
`default_nettype wire

/* File: test_vout_protection_fault_response.sv */
// Self-checking bench for the output-voltage protection block.
// Assumes the host model vpfr_host; retry count shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_vout_protection_fault_response;
   import vpfr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid, write, word, rdv, err, oe, sclr, dac5;
   logic [7:0] code, page, nvm_uv, mask, shift, sva, svb, sba, sbb, ta, vmax;
   logic [15:0] wdata, rdata;
   logic [1:0] en, ov, uv, run, on, sw, mhi;
   int n_mismatch = 0;
   int total_checks = 0;
   int seed = 23609;
   logic [16:0] expq[$];
   vpfr_top #(.RETRY_CYCLES(20)) dut (.SYS_CLK(clk), .SYS_RST(rst), .CMD_VALID(valid),
      .CMD_WRITE(write), .CMD_WORD(word), .CMD_CODE(code), .CMD_WDATA(wdata), .PAGE_SEL(page),
      .STATUS_CLEAR(sclr), .RD_VALID(rdv), .RD_DATA(rdata), .CMD_ERROR(err),
      .NVM_VMAX_A(8'hC0), .NVM_VMAX_B(8'hC0), .NVM_UV_ACTION(nvm_uv), .OPER_ON(on),
      .MARGIN_HIGH_ON(mhi), .MARGIN_LOW_ON(2'b00), .DAC_5MV_SEL(dac5),
      .LOADLINE_SHIFT_A(shift), .LOADLINE_SHIFT_B(shift), .ALERT_MASK_VOUT(mask),
      .CHANNEL_ENABLE_PINS(en), .OV_COMP_PINS(ov), .UV_COMP_PINS(uv), .CHANNEL_RUN(run),
      .VOUT_TARGET_A(ta), .VOUT_TARGET_B(), .STATUS_VOUT_A(sva), .STATUS_VOUT_B(svb),
      .STATUS_BYTE_A(sba), .STATUS_BYTE_B(sbb), .STATUS_WORD_VOUT(sw),
      .HOST_ALERT_PIN_O(), .HOST_ALERT_PIN_OE(oe));
   vpfr_host host (.clk(clk), .valid(valid), .write(write), .word(word), .code(code),
      .wdata(wdata), .page(page));
   initial forever #25 clk = ~clk;
   task automatic bad(input string m);
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask : bad
   task automatic cmpr(input logic [16:0] got, input logic [16:0] exp);
      total_checks++;
      if (got !== exp) bad($sformatf("answer %h exp %h", got, exp));
   endtask : cmpr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) bad($sformatf("level %h exp %h", got, exp));
   endtask : chk
   // Top bit of e says an answer is due; it is noted before the request goes out
   task automatic cmd(input logic w, wd, input logic [7:0] c, input logic [15:0] d,
      input logic [7:0] p, input logic [17:0] e);
      if (e[17]) expq.push_back(e[16:0]);
      host.send(w, wd, c, d, p);
   endtask : cmd
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   task automatic wrap_up;
      if (expq.size() != 0) bad("answers missing");
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      if (rdv === 1'b1 || err === 1'b1) begin
         if (expq.size() == 0) bad("unexpected answer");
         else cmpr({err, rdata}, expq.pop_front());
      end
   end
   initial begin
      #100000;
      bad("timeout");
      wrap_up;
   end
   // ************************************************
   // Scenarios
   // ************************************************
   initial begin
      {sclr, dac5, en, ov, uv, on, mhi} = '0;
      nvm_uv = ACT_LATCH;
      mask = 8'h00;
      shift = 8'h02;
      vmax = 8'h30 + 8'($random(seed) & 32'h7F);
      tick(2);
      rst = 1'b0;
      cmd(0, 1, CMD_VMAX, 0, PAGE_B, {2'b10, 16'h00C0});
      cmd(0, 0, CMD_UVRESP, 0, PAGE_A, {2'b10, 16'h0080});
      cmd(0, 0, CMD_OVRESP, 0, PAGE_B, {2'b10, 16'h0080});
      cmd(1, 0, CMD_OVRESP, 16'h00BA, PAGE_A, {2'b11, 16'h0});
      cmd(0, 1, CMD_OVRESP, 0, PAGE_A, {2'b11, 16'h0});
      cmd(1, 1, CMD_VMAX, {8'hA5, vmax}, PAGE_ALL, '0);
      cmd(0, 1, CMD_VMAX, 0, PAGE_A, {2'b10, 8'h00, vmax});
      cmd(0, 1, CMD_VMAX, 0, PAGE_B, {2'b10, 8'h00, vmax});
      cmd(0, 1, CMD_OVLIM, 0, PAGE_B, {2'b10, 8'h00, vmax + OV_OFFSET});
      dac5 = 1'b1;
      cmd(0, 1, CMD_OVLIM, 0, PAGE_A, {2'b10, 16'h00FF});
      cmd(1, 1, CMD_OVLIM, 0, PAGE_A, {2'b11, 16'h0});
      cmd(0, 1, CMD_UVLIM, 0, 8'h02, {2'b11, 16'h0});
      cmd(1, 0, CMD_UVRESP, 16'h0055, PAGE_A, {2'b11, 16'h0});
      cmd(1, 0, CMD_UVRESP, 16'h00BA, PAGE_A, '0);
      cmd(0, 0, CMD_UVRESP, 0, PAGE_B, {2'b10, 16'h00BA});
      cmd(1, 1, CMD_VOUT, 16'h00FF, PAGE_A, '0);
      tick(6);
      chk(ta, vmax);
      chk(sva & 8'h98, 8'h08);
      chk({4'h0, sba[5], sba[0], sw[0], oe}, 8'h07);
      cmd(0, 1, CMD_UVLIM, 0, PAGE_A, {2'b10, 8'h00, vmax - 8'h0C});
      mask = 8'h08;
      sclr = 1'b1;
      tick(1);
      sclr = 1'b0;
      cmd(1, 1, CMD_VOUT, 16'h00FF, PAGE_A, '0);
      tick(6);
      chk({sva[3], oe}, 2'b10);
      mask = 8'h00;
      {on, en} = 4'hF;
      tick(8);
      chk(run, 2'b11);
      ov[0] = 1'b1;
      tick(6);
      ov[0] = 1'b0;
      chk({sva[7], sba[5], run[0], oe}, 4'hD);
      tick(8);
      chk(run[0], 1'b0);
      en[0] = 1'b0;
      tick(6);
      en[0] = 1'b1;
      tick(8);
      chk(run[0], 1'b1);
      uv[1] = 1'b1;
      tick(6);
      uv[1] = 1'b0;
      chk({svb[4], sbb[0], run[1]}, 3'b110);
      tick(12);
      chk(run, 2'b01);
      tick(18);
      chk(run, 2'b11);
      cmd(1, 0, CMD_UVRESP, 16'h0000, PAGE_B, '0);
      sclr = 1'b1;
      tick(1);
      sclr = 1'b0;
      uv[1] = 1'b1;
      tick(6);
      chk({svb[4], run[1]}, 2'b11);
      uv[1] = 1'b0;
      cmd(1, 1, CMD_MHI, 16'h0020, PAGE_A, '0);
      mhi = 2'b01;
      tick(3);
      chk(ta, 8'h20);
      tick(4);
      wrap_up;
   end
endmodule : test_vout_protection_fault_response
`default_nettype wire
